// ### hdl/cfsa_core.sv
// Behaviour
// R1 - Unblock data is empty or 16 bytes: unblock secret then new secret.
// R2 - Deactivate a file only when its deactivation condition is met; reversible.
// R3 - Reactivate a file only when its activation condition is met.
// R4 - Successful activate or deactivate makes the addressed file current.
// R5 - Failed activate or deactivate leaves current file and directory unchanged.
// R6 - Deactivated file refuses every operation except select and reactivate; here only file use is refused, a repeated deactivate still succeeds.
// R7 - Addressing byte 00 by id, 08 path from master, 09 from directory; second zero.
// R8 - Both parameter bytes zero and no data: act on the current file.
// R9 - Terminal selects a suitable application before authenticating.
// R10 - Even code only for unwrapped challenges shorter than 256 bytes.
// R11 - Odd code data wrapped with tag 73 if structured, else 53.
// R12 - Odd code data chained in blocks of at most 255 bytes, reassembled.
// R13 - Terminal marks first block, then next blocks of the same chain.
// R14 - Return 63F1 while challenge blocks are outstanding, 62F3 when complete.
// R15 - First response request runs the computation; segments follow in order.
// R16 - Delivering the last response segment completes with 9000.
// R17 - Resend request repeats the previous block without restarting the chain.
// R18 - Odd code support is optional per application.
// R19 - Block type: 100,000,010 challenge first/next/resend; 101,001,011 response.
// R20 - Correct unblock secret installs new secret, retries 10 and 3, enables.
// R21 - Wrong unblock secret decrements, returns 63CX; tenth blocks; then 6983.
// R22 - Pending response segments are signalled by a distinct status word.
// R23 - Reserved parameter values or mismatched data length are rejected.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cfsa_core (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cfsa_pkg::*;

  function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] b);
    return {a[26:0], a[31:27]} ^ b;
  endfunction

  function automatic logic [7:0] dByte(input logic [127:0] d, input logic [7:0] i);
    return d[{i[3:0], 3'b000} +: 8];
  endfunction

  function automatic logic [7:0] respByte(input logic [31:0] k, input logic [7:0] i);
    logic [31:0] x;
    x = mix(k, {24'h00_0000, i}) ^ {k[15:0], k[31:16]};
    if (i == 8'h00) return TAG_PRIM;
    if (i == 8'h01) return RESP_LEN;
    return x[7:0] ^ x[23:16];
  endfunction

  cfsa_cmd_t cmd_r, cmd_nxt;
  cfsa_auth_t aState_r, aState_nxt;
  logic go_r, go_nxt, rdDone_r, rdDone_nxt;
  logic [31:0] prdata_nxt;
  logic [127:0] data_r, data_nxt;
  logic [16:0] ctrl_r, ctrl_nxt;
  logic [2:0] curEf_r, curEf_nxt;
  logic efValid_r, efValid_nxt;
  logic [15:0] df_r, df_nxt, sw_r, sw_nxt;
  logic [NFILE-1:0] deact_r, deact_nxt;
  logic [63:0] pin_r, pin_nxt;
  logic [3:0] ubRetry_r, ubRetry_nxt;
  logic [1:0] pinRetry_r, pinRetry_nxt;
  logic pinEn_r, pinEn_nxt;
  logic [31:0] blkDig_r, blkDig_nxt, digest_r, digest_nxt, prevDig_r, prevDig_nxt, key_r, key_nxt;
  logic [7:0] blkCnt_r, blkCnt_nxt;
  logic [23:0] hdr_r, hdr_nxt;
  logic [15:0] rxTot_r, rxTot_nxt, prevRx_r, prevRx_nxt, expTot_r, expTot_nxt;
  logic [7:0] segStart_r, segStart_nxt, segLen_r, segLen_nxt, popIdx_r, popIdx_nxt;
  logic [7:0] segEnd, popByte, rsStart, rsRemain;
  logic [15:0] tFid, chRx;
  logic [31:0] chDig;
  logic [2:0] tIdx;
  logic tHit, p1Bad, lenBad, fileCmd, rdReq, wrEn, mapped, chOk, rsOk;
  logic [1:0] dIdx;

  assign segEnd = segStart_r + segLen_r;
  assign popByte = (popIdx_r < segLen_r) ? respByte(key_r, segStart_r + popIdx_r) : 8'h00;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= A_PIN);
  assign rdReq = psel & penable & ~pwrite & ~rdDone_r;
  assign wrEn = psel & penable & pwrite;
  // Reads take one wait state so that a status read right after a command sees its result.
  assign pready = penable & (pwrite | rdDone_r);
  assign pslverr = psel & penable & ~mapped;
  assign fileCmd = (cmd_r.op == OP_DEACT) || (cmd_r.op == OP_REACT);
  assign dIdx = 2'(paddr[4:2] - 3'd1);

  // Target file decode for the activation commands.
  always_comb begin
    tFid = {dByte(data_r, cmd_r.len - 8'd2), dByte(data_r, cmd_r.len - 8'd1)};
    tHit = 1'b0;
    tIdx = curEf_r;
    if (cmd_r.len == 8'h00) begin
      tHit = efValid_r; // [R8]
    end else begin
      for (int i = 0; i < NFILE; i++) begin
        if (tFid == FID_BASE + 16'(i)) begin
          tHit = 1'b1;
          tIdx = 3'(i);
        end
      end
    end
    p1Bad = (cmd_r.p2 != 8'h00) || !((cmd_r.p1 == P1_FID) || (cmd_r.p1 == P1_PATH_MF) ||
            (cmd_r.p1 == P1_PATH_DF)); // [R7] [R23]
    // Path addressing resolves only the final file id; intermediate directories are not walked.
    if (cmd_r.p1 == P1_FID) begin
      lenBad = (cmd_r.len != 8'h00) && (cmd_r.len != FID_LEN); // [R23]
    end else begin
      lenBad = (cmd_r.len < FID_LEN) || cmd_r.len[0] || (cmd_r.len > PATH_MAX); // [R23]
    end
  end

  always_comb begin
    cmd_nxt = cmd_r;
    aState_nxt = aState_r;
    go_nxt = 1'b0;
    rdDone_nxt = rdReq;
    prdata_nxt = prdata;
    data_nxt = data_r;
    ctrl_nxt = ctrl_r;
    curEf_nxt = curEf_r;
    efValid_nxt = efValid_r;
    df_nxt = df_r;
    sw_nxt = sw_r;
    deact_nxt = deact_r;
    pin_nxt = pin_r;
    ubRetry_nxt = ubRetry_r;
    pinRetry_nxt = pinRetry_r;
    pinEn_nxt = pinEn_r;
    blkDig_nxt = blkDig_r;
    digest_nxt = digest_r;
    prevDig_nxt = prevDig_r;
    key_nxt = key_r;
    blkCnt_nxt = blkCnt_r;
    hdr_nxt = hdr_r;
    rxTot_nxt = rxTot_r;
    prevRx_nxt = prevRx_r;
    expTot_nxt = expTot_r;
    segStart_nxt = segStart_r;
    segLen_nxt = segLen_r;
    popIdx_nxt = popIdx_r;
    chOk = 1'b0;
    chDig = digest_r;
    chRx = rxTot_r;
    rsOk = 1'b0;
    rsStart = segStart_r;
    rsRemain = 8'h00;
    if (wrEn) begin
      if (paddr == A_CMD) begin
        cmd_nxt = cfsa_cmd_t'(pwdata);
        go_nxt = 1'b1;
      end else if ((paddr >= A_DATA0) && (paddr <= A_DATA3) && (paddr[1:0] == 2'b00)) begin
        data_nxt[32*dIdx +: 32] = pwdata;
      end else if (paddr == A_PUSH) begin
        // Challenge bytes are folded into a digest; a block holds at most 255 bytes.
        blkDig_nxt = mix(blkDig_r, {24'h00_0000, pwdata[7:0]}); // [R12]
        if (blkCnt_r < 8'd3) hdr_nxt[{blkCnt_r[1:0], 3'b000} +: 8] = pwdata[7:0];
        if (blkCnt_r != 8'hFF) blkCnt_nxt = blkCnt_r + 8'd1;
      end else if (paddr == A_CTRL) begin
        ctrl_nxt = pwdata[16:0];
      end else if (paddr == A_CUR) begin
        curEf_nxt = pwdata[2:0];
        efValid_nxt = pwdata[3];
        df_nxt = pwdata[31:16];
      end
    end
    if (rdReq) begin
      case (paddr)
        A_CMD: prdata_nxt = cmd_r;
        A_PUSH: prdata_nxt = {24'h00_0000, blkCnt_r};
        A_POP: prdata_nxt = {24'h00_0000, popByte};
        A_STATUS: prdata_nxt = {13'h0000, 2'(aState_r), go_r, sw_r};
        A_CTRL: prdata_nxt = {15'h0000, ctrl_r};
        A_CUR: prdata_nxt = {df_r, 12'h000, efValid_r, curEf_r};
        A_FILES: prdata_nxt = {{(32-NFILE){1'b0}}, deact_r};
        A_PIN: prdata_nxt = {25'h000_0000, pinEn_r, pinRetry_r, ubRetry_r};
        default: prdata_nxt = (mapped && paddr <= A_DATA3) ? data_r[32*dIdx +: 32] : 32'h0000_0000;
      endcase
      if (paddr == A_POP && popIdx_r < segLen_r) popIdx_nxt = popIdx_r + 8'd1; // [R15]
    end
    if (go_r) begin
      sw_nxt = SW_OK;
      blkCnt_nxt = 8'h00;
      blkDig_nxt = 32'h0000_0000;
      case (cmd_r.op)
        OP_UNBLOCK: begin
          if (cmd_r.p1 != 8'h00) begin
            sw_nxt = SW_BAD_P1P2; // [R23]
          end else if (cmd_r.len != 8'h00 && cmd_r.len != UB_LEN) begin
            sw_nxt = SW_BAD_LEN; // [R1]
          end else if (ubRetry_r == 4'h0) begin
            sw_nxt = SW_UB_BLOCKED; // [R21]
          end else if (cmd_r.len == 8'h00) begin
            sw_nxt = {SW_RETRY_HI, ubRetry_r};
          end else if (data_r[63:0] == UB_SECRET) begin
            pin_nxt = data_r[127:64]; // [R1] [R20]
            ubRetry_nxt = UB_RETRY_INIT;
            pinRetry_nxt = PIN_RETRY_INIT;
            pinEn_nxt = 1'b1;
          end else begin
            ubRetry_nxt = ubRetry_r - 4'h1; // [R21]
            sw_nxt = {SW_RETRY_HI, ubRetry_r - 4'h1};
          end
        end
        OP_DEACT, OP_REACT: begin
          // On any failure the current file and directory are left untouched. [R5]
          if (p1Bad) begin
            sw_nxt = SW_BAD_P1P2; // [R7]
          end else if (lenBad) begin
            sw_nxt = SW_BAD_LEN; // [R23]
          end else if (!tHit) begin
            sw_nxt = SW_NOT_FOUND;
          end else if (!ctrl_r[(cmd_r.op == OP_DEACT) ? {1'b0, tIdx} : {1'b1, tIdx}]) begin
            sw_nxt = SW_AC_FAIL; // [R2] [R3]
          end else begin
            deact_nxt[tIdx] = (cmd_r.op == OP_DEACT); // [R2] [R3]
            curEf_nxt = tIdx; // [R4]
            efValid_nxt = 1'b1;
          end
        end
        OP_FILE_USE: begin
          if (!efValid_r) sw_nxt = SW_NOT_FOUND;
          else if (deact_r[curEf_r]) sw_nxt = SW_DEACT; // [R6]
        end
        OP_AUTH_EVEN: begin
          if (!ctrl_r[16]) begin
            sw_nxt = SW_COND; // [R9]
          end else if (cmd_r.p1 != 8'h00) begin
            sw_nxt = SW_BAD_P1P2;
          end else if (cmd_r.len == 8'h00 || cmd_r.len != blkCnt_r) begin
            sw_nxt = SW_BAD_LEN; // [R10]
          end else begin
            key_nxt = blkDig_r;
            segStart_nxt = RESP_BODY;
            segLen_nxt = RESP_LEN;
            popIdx_nxt = 8'h00;
            aState_nxt = AU_IDLE;
          end
        end
        OP_AUTH_ODD: begin
          if (!ODD_SUPPORT) begin
            sw_nxt = SW_BAD_INS; // [R18]
          end else if (!ctrl_r[16]) begin
            sw_nxt = SW_COND; // [R9]
          end else if (cmd_r.p1[4:0] != 5'h00) begin
            sw_nxt = SW_BAD_P1P2;
          end else begin
            case (cmd_r.p1[7:5]) // [R19]
              BT_FIRST_CH: begin
                if (cmd_r.len == 8'h00 || cmd_r.len != blkCnt_r) begin
                  sw_nxt = SW_BAD_LEN;
                end else if (hdr_r[7:0] != TAG_CONS && hdr_r[7:0] != TAG_PRIM) begin
                  sw_nxt = SW_BAD_DATA; // [R11]
                end else if (hdr_r[15:8] < SHORT_LEN_MAX && blkCnt_r >= 8'd2) begin
                  expTot_nxt = {8'h00, hdr_r[15:8]} + 16'h0002;
                  chOk = 1'b1;
                end else if (hdr_r[15:8] == LEN_EXT1 && blkCnt_r >= 8'd3) begin
                  expTot_nxt = {8'h00, hdr_r[23:16]} + 16'h0003;
                  chOk = 1'b1;
                end else begin
                  sw_nxt = SW_BAD_DATA;
                end
                chDig = blkDig_r;
                chRx = {8'h00, cmd_r.len};
                prevDig_nxt = 32'h0000_0000;
                prevRx_nxt = 16'h0000;
              end
              BT_NEXT_CH: begin
                if (aState_r != AU_CHAL) sw_nxt = SW_COND; // [R13]
                else if (cmd_r.len == 8'h00 || cmd_r.len != blkCnt_r) sw_nxt = SW_BAD_LEN;
                else chOk = 1'b1;
                chDig = mix(digest_r, blkDig_r); // [R12]
                chRx = rxTot_r + {8'h00, cmd_r.len};
                if (chOk) prevDig_nxt = digest_r;
                if (chOk) prevRx_nxt = rxTot_r;
              end
              BT_RESEND_CH: begin
                // The last block is replaced, not appended. [R17]
                if (aState_r != AU_CHAL && aState_r != AU_READY) sw_nxt = SW_COND;
                else if (cmd_r.len == 8'h00 || cmd_r.len != blkCnt_r) sw_nxt = SW_BAD_LEN;
                else chOk = 1'b1;
                chDig = mix(prevDig_r, blkDig_r);
                chRx = prevRx_r + {8'h00, cmd_r.len};
              end
              BT_FIRST_RS: begin
                if (aState_r != AU_READY && aState_r != AU_RESP) begin
                  sw_nxt = SW_COND;
                end else begin
                  key_nxt = digest_r; // [R15]
                  rsStart = 8'h00;
                  rsOk = 1'b1;
                end
              end
              BT_NEXT_RS: begin
                if (aState_r != AU_RESP || segEnd == RESP_TOT) begin
                  sw_nxt = SW_COND;
                end else begin
                  rsStart = segEnd; // [R15]
                  rsOk = 1'b1;
                end
              end
              BT_RESEND_RS: begin
                if (aState_r != AU_RESP) sw_nxt = SW_COND;
                else rsOk = 1'b1; // [R17]
              end
              default: sw_nxt = SW_BAD_P1P2;
            endcase
          end
          if (chOk) begin
            digest_nxt = chDig;
            rxTot_nxt = chRx;
            sw_nxt = (chRx >= expTot_nxt) ? SW_CH_DONE : SW_MORE_CH; // [R14]
            aState_nxt = (chRx >= expTot_nxt) ? AU_READY : AU_CHAL;
          end
          if (rsOk) begin
            rsRemain = RESP_TOT - rsStart;
            segStart_nxt = rsStart;
            segLen_nxt = (cmd_r.len == 8'h00 || cmd_r.len > rsRemain) ? rsRemain : cmd_r.len;
            popIdx_nxt = 8'h00;
            aState_nxt = AU_RESP;
            if (rsStart + segLen_nxt != RESP_TOT) begin
              sw_nxt = {SW_MORE_RESP_HI, RESP_TOT - rsStart - segLen_nxt}; // [R22]
            end // Otherwise the status stays at completion. [R16]
          end
        end
        default: sw_nxt = SW_BAD_INS;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= '0;
      aState_r <= AU_IDLE;
      go_r <= 1'b0;
      rdDone_r <= 1'b0;
      prdata <= 32'h0000_0000;
      data_r <= '0;
      ctrl_r <= CTRL_RST;
      curEf_r <= 3'h0;
      efValid_r <= 1'b0;
      df_r <= 16'h0000;
      sw_r <= SW_OK;
      deact_r <= '0;
      pin_r <= PIN_RST;
      ubRetry_r <= UB_RETRY_INIT;
      pinRetry_r <= PIN_RETRY_INIT;
      pinEn_r <= 1'b1;
      blkDig_r <= 32'h0000_0000;
      digest_r <= 32'h0000_0000;
      prevDig_r <= 32'h0000_0000;
      key_r <= 32'h0000_0000;
      blkCnt_r <= 8'h00;
      hdr_r <= 24'h00_0000;
      rxTot_r <= 16'h0000;
      prevRx_r <= 16'h0000;
      expTot_r <= 16'h0000;
      segStart_r <= 8'h00;
      segLen_r <= 8'h00;
      popIdx_r <= 8'h00;
    end else begin
      cmd_r <= cmd_nxt;
      aState_r <= aState_nxt;
      go_r <= go_nxt;
      rdDone_r <= rdDone_nxt;
      prdata <= prdata_nxt;
      data_r <= data_nxt;
      ctrl_r <= ctrl_nxt;
      curEf_r <= curEf_nxt;
      efValid_r <= efValid_nxt;
      df_r <= df_nxt;
      sw_r <= sw_nxt;
      deact_r <= deact_nxt;
      pin_r <= pin_nxt;
      ubRetry_r <= ubRetry_nxt;
      pinRetry_r <= pinRetry_nxt;
      pinEn_r <= pinEn_nxt;
      blkDig_r <= blkDig_nxt;
      digest_r <= digest_nxt;
      prevDig_r <= prevDig_nxt;
      key_r <= key_nxt;
      blkCnt_r <= blkCnt_nxt;
      hdr_r <= hdr_nxt;
      rxTot_r <= rxTot_nxt;
      prevRx_r <= prevRx_nxt;
      expTot_r <= expTot_nxt;
      segStart_r <= segStart_nxt;
      segLen_r <= segLen_nxt;
      popIdx_r <= popIdx_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_ub_ok;
    go_r && cmd_r.op == OP_UNBLOCK && cmd_r.p1 == 8'h00 && cmd_r.len == UB_LEN && ubRetry_r != 4'h0 &&
      data_r[63:0] == UB_SECRET |=> ubRetry_r == UB_RETRY_INIT && pinRetry_r == PIN_RETRY_INIT && pinEn_r &&
      sw_r == SW_OK && pin_r == $past(data_r[127:64]);
  endproperty
  a_ub_ok: assert property (p_ub_ok) else $error("unblock success state wrong"); // [R20]

  property p_ub_bad;
    go_r && cmd_r.op == OP_UNBLOCK && cmd_r.p1 == 8'h00 && cmd_r.len == UB_LEN && ubRetry_r != 4'h0 &&
      data_r[63:0] != UB_SECRET |=> ubRetry_r == $past(ubRetry_r) - 4'h1 && sw_r == {SW_RETRY_HI, ubRetry_r};
  endproperty
  a_ub_bad: assert property (p_ub_bad) else $error("wrong unblock secret not counted"); // [R21]

  property p_ub_blk;
    go_r && cmd_r.op == OP_UNBLOCK && cmd_r.p1 == 8'h00 && ubRetry_r == 4'h0 &&
      (cmd_r.len == UB_LEN || cmd_r.len == 8'h00) |=> sw_r == SW_UB_BLOCKED;
  endproperty
  a_ub_blk: assert property (p_ub_blk) else $error("blocked unblock not refused"); // [R21]

  property p_deact_ac;
    go_r && cmd_r.op == OP_DEACT && !ctrl_r[tIdx] |=> sw_r != SW_OK && deact_r == $past(deact_r);
  endproperty
  a_deact_ac: assert property (p_deact_ac) else $error("deactivation without access"); // [R2]

  property p_react_ac;
    go_r && cmd_r.op == OP_REACT && tHit && !p1Bad && !lenBad && ctrl_r[NFILE + int'(tIdx)]
      |=> sw_r == SW_OK && !deact_r[$past(tIdx)];
  endproperty
  a_react_ac: assert property (p_react_ac) else $error("reactivation did not clear flag"); // [R3]

  property p_cur_ok;
    go_r && fileCmd ##1 sw_r == SW_OK |-> curEf_r == $past(tIdx) && efValid_r;
  endproperty
  a_cur_ok: assert property (p_cur_ok) else $error("current file not updated"); // [R4]

  property p_cur_keep;
    go_r && fileCmd ##1 sw_r != SW_OK |-> $stable(curEf_r) && $stable(df_r) && $stable(efValid_r);
  endproperty
  a_cur_keep: assert property (p_cur_keep) else $error("failed command moved current file"); // [R5]

  property p_use_deact;
    go_r && cmd_r.op == OP_FILE_USE && efValid_r && deact_r[curEf_r] |=> sw_r == SW_DEACT;
  endproperty
  a_use_deact: assert property (p_use_deact) else $error("deactivated file used"); // [R6]

  property p_chain_done;
    $past(go_r) && aState_r == AU_READY && $past(aState_r) != AU_READY |-> sw_r == SW_CH_DONE;
  endproperty
  a_chain_done: assert property (p_chain_done) else $error("chain end status wrong"); // [R14]

  property p_resp_more;
    sw_r[15:8] == SW_MORE_RESP_HI |-> aState_r == AU_RESP && sw_r[7:0] == RESP_TOT - segEnd;
  endproperty
  a_resp_more: assert property (p_resp_more) else $error("pending status inconsistent"); // [R22]

  property p_resp_done;
    $past(go_r) && aState_r == AU_RESP && $past(aState_r) != AU_RESP && segEnd == RESP_TOT |-> sw_r == SW_OK;
  endproperty
  a_resp_done: assert property (p_resp_done) else $error("last segment not completed"); // [R16]

  property p_rd_wait;
    psel && penable && !pwrite && !pready |=> pready;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state too long");
endmodule
`default_nettype wire

// ### hdl/cfsa_pkg.sv
`default_nettype none
package cfsa_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DATA0 = 8'h04;
  localparam logic [7:0] A_DATA3 = 8'h10;
  localparam logic [7:0] A_PUSH = 8'h14;
  localparam logic [7:0] A_POP = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_CUR = 8'h24;
  localparam logic [7:0] A_FILES = 8'h28;
  localparam logic [7:0] A_PIN = 8'h2C;
  // File table.
  localparam int NFILE = 8;
  localparam logic [15:0] FID_BASE = 16'h6F00;
  // Command codes.
  localparam logic [7:0] OP_UNBLOCK = 8'h00;
  localparam logic [7:0] OP_DEACT = 8'h01;
  localparam logic [7:0] OP_REACT = 8'h02;
  localparam logic [7:0] OP_AUTH_EVEN = 8'h03;
  localparam logic [7:0] OP_AUTH_ODD = 8'h04;
  localparam logic [7:0] OP_FILE_USE = 8'h05;
  // Parameter bytes and lengths.
  localparam logic [7:0] P1_FID = 8'h00;
  localparam logic [7:0] P1_PATH_MF = 8'h08;
  localparam logic [7:0] P1_PATH_DF = 8'h09;
  localparam logic [7:0] UB_LEN = 8'h10;
  localparam logic [7:0] FID_LEN = 8'h02;
  localparam logic [7:0] PATH_MAX = 8'h10;
  // Secrets and retry counters after reset; secret values are arbitrary.
  localparam logic [63:0] UB_SECRET = 64'h3837_3635_3433_3231;
  localparam logic [63:0] PIN_RST = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [3:0] UB_RETRY_INIT = 4'hA;
  localparam logic [1:0] PIN_RETRY_INIT = 2'h3;
  localparam logic [16:0] CTRL_RST = 17'h0_FFFF;
  // Wrapping of authentication data.
  localparam logic [7:0] TAG_CONS = 8'h73;
  localparam logic [7:0] TAG_PRIM = 8'h53;
  localparam logic [7:0] LEN_EXT1 = 8'h81;
  localparam logic [7:0] SHORT_LEN_MAX = 8'h80;
  localparam bit ODD_SUPPORT = 1'b1;
  // Block types in the top three bits of the first parameter byte.
  localparam logic [2:0] BT_FIRST_CH = 3'b100;
  localparam logic [2:0] BT_NEXT_CH = 3'b000;
  localparam logic [2:0] BT_RESEND_CH = 3'b010;
  localparam logic [2:0] BT_FIRST_RS = 3'b101;
  localparam logic [2:0] BT_NEXT_RS = 3'b001;
  localparam logic [2:0] BT_RESEND_RS = 3'b011;
  // Status words.
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_MORE_CH = 16'h63F1;
  localparam logic [15:0] SW_CH_DONE = 16'h62F3;
  localparam logic [7:0] SW_MORE_RESP_HI = 8'h61;
  localparam logic [11:0] SW_RETRY_HI = 12'h63C;
  localparam logic [15:0] SW_UB_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_AC_FAIL = 16'h6982;
  localparam logic [15:0] SW_COND = 16'h6985;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
  localparam logic [15:0] SW_BAD_LEN = 16'h6700;
  localparam logic [15:0] SW_BAD_DATA = 16'h6A80;
  localparam logic [15:0] SW_DEACT = 16'h6283;
  localparam logic [15:0] SW_BAD_INS = 16'h6D00;
  // Authentication response object: tag, length byte and payload.
  localparam logic [7:0] RESP_LEN = 8'h20;
  localparam logic [7:0] RESP_TOT = 8'h22;
  localparam logic [7:0] RESP_BODY = 8'h02;

  typedef struct packed {
    logic [7:0] len;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] op;
  } cfsa_cmd_t;

  typedef enum logic [1:0] {AU_IDLE, AU_CHAL, AU_READY, AU_RESP} cfsa_auth_t;
endpackage
`default_nettype wire

// ### testbench/cfsa_terminal.sv
`timescale 1ns/1ps
`default_nettype none
module cfsa_terminal (
  // Clock.
  input wire logic clk_sys,
  // APB master.
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {paddr, psel, penable, pwrite, pwdata} = '0;
  // Callers select the application first, send only wrapped chained blocks and mark each one.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic t);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Sampling half a period early avoids racing the edge that updates ready and read data.
    while (!ok && n < 16) begin
      @(negedge clk_sys);
      ok = (pready === 1'b1);
      q = prdata;
      e = pslverr;
      n++;
      @(posedge clk_sys);
    end
    t = !ok;
    {psel, penable} <= 2'b00;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_card_file_state_and_auth_commands.sv
`timescale 1ns/1ps
`default_nettype none
module test_card_file_state_and_auth_commands;
  import cfsa_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err, to;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0, compares = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  cfsa_core i_dut (.clk_sys, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  cfsa_terminal i_term (.clk_sys, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] x, input logic [31:0] v);
    compares++;
    fail_count += int'(v !== x);
    if (v !== x) $display("mismatch %s expected %h seen %h", s, x, v);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_term.xfer(w, a, d, rd, err, to);
    fail_count += int'(to);
    if (to) complete_run();
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    check(s, x, rd);
  endtask
  task automatic cmd(input logic [31:0] d, input logic [31:0] c, input logic [15:0] sw);
    bus(1'b1, A_DATA0, d);
    bus(1'b1, A_CMD, c);
    bus(1'b0, A_STATUS, 32'h0000_0000);
    check("status", {16'h0000, sw}, {16'h0000, rd[15:0]});
  endtask
  task automatic push(input logic [7:0] b[$]);
    foreach (b[i]) bus(1'b1, A_PUSH, {24'h00_0000, b[i]});
  endtask
  task automatic fileStates();
    rdchk("pin", A_PIN, 32'h0000_007A);
    bus(1'b0, 8'h30, 32'h0000_0000);
    check("slverr", 32'h0000_0001, 32'(err));
    bus(1'b1, A_CTRL, 32'h0001_FFDF);
    cmd(32'h0000_036F, 32'h0200_0001, SW_OK);
    rdchk("files", A_FILES, 32'h0000_0008);
    cmd(32'h0000_036F, 32'h0000_0005, SW_DEACT);
    cmd(32'h0000_056F, 32'h0200_0001, SW_AC_FAIL);
    cmd(32'h0000_056F, 32'h0200_0101, SW_BAD_P1P2);
    rdchk("current", A_CUR, 32'h0000_000B);
    cmd(32'h0000_0000, 32'h0000_0002, SW_OK);
    cmd(32'h016F_003F, 32'h0400_0801, SW_OK);
    rdchk("files", A_FILES, 32'h0000_0002);
    cmd(32'h016F_003F, 32'h0400_0902, SW_OK);
  endtask
  task automatic unblockAuth();
    cmd(32'h0000_0000, 32'h1000_0000, 16'h63C9);
    bus(1'b1, A_DATA0 + 8'h04, 32'h3837_3635);
    cmd(32'h3433_3231, 32'h1000_0000, SW_OK);
    rdchk("pin", A_PIN, 32'h0000_007A);
    push('{8'h53, 8'h81, 8'h04, 8'hAA, 8'hBB});
    cmd(32'h0000_0000, 32'h0500_8004, SW_MORE_CH);
    push('{8'hCC, 8'hDD});
    cmd(32'h0000_0000, 32'h0200_0004, SW_CH_DONE);
    cmd(32'h0000_0000, 32'h1000_A004, 16'h6112);
    rdchk("response", A_POP, 32'h0000_0053);
    cmd(32'h0000_0000, 32'h1000_6004, 16'h6112);
    cmd(32'h0000_0000, 32'h0000_2004, SW_OK);
    for (int i = 9; i >= 0; i--) cmd(32'h0000_0000, 32'h1000_0000, {12'h63C, 4'(i)});
    cmd(32'h0000_0000, 32'h1000_0000, SW_UB_BLOCKED);
    cmd(32'h0000_0000, 32'h0000_0000, SW_UB_BLOCKED);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    fileStates();
    unblockAuth();
    complete_run();
  end
endmodule
`default_nettype wire
